// file: sdc_ctrl.sv
// Test-signal and reference sine generation with dual-slope converter sequencing
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Every clock, trigger and test frequency is divided digitally from one time base.
// - Processor selects 100 Hz, 120 Hz, 1 kHz or 10 kHz via the freq_sel code.
// - Binary halving stages from the step clock give 32f down to f squares.
// - Divider outputs address a test sine table of sixty-four steps per cycle.
// - Each table entry goes out as an eight-bit word to the test converter.
// - Smoothing filter selection follows the chosen test frequency.
// - A second table on the same address gives a zero-phase reference sine.
// - Processor command shifts reference phase by 90, 180 or 270 degrees.
// - Four reference phases exactly a quarter cycle apart at test frequency.
// - Converter stages act only on the processor's control port signals.
// - Integrator first samples multiplier output for a fixed interval.
// - Then deintegrate at reference rate until zero-cross comparator reports zero.
// - Counter runs only during deintegration; final count is the result.
// - Limit comparator during sampling starts deintegration while sampling continues.
// - Flag too-long fault and abort when zero not reached in bounded time.
// - Flag too-short fault and abort when already zero at deintegration start.
module sdc_ctrl #(
    parameter int SAMPLE_CYCLES = sdc_pkg::SAMPLE_CYC, // Sampling interval in clocks
    parameter int TIMEOUT_CYCLES = sdc_pkg::TIMEOUT_CYC // Deintegration timeout in clocks
) (
    input wire logic clk, // System clock, 200 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic [1:0] freq_sel, // Test frequency code
    input wire logic [1:0] phase_sel, // Reference phase code
    input wire logic conv_start, // Start one conversion, pulse
    input wire logic zero_cross_compare_n, // Low when integrator is at or past zero
    input wire logic integrator_limit_n, // Low when integrator reaches its limit
    output logic step_clk_q, // Square wave at 64 f
    output logic [sdc_pkg::ADDR_W-1:0] div_sq_q, // Squares 32f (bit 0) down to f (bit 5)
    output logic [sdc_pkg::DAC_W-1:0] test_dac_q, // Test sine word
    output logic [sdc_pkg::DAC_W-1:0] ref_dac_q, // Reference sine word
    output logic [1:0] filter_sel_q, // Smoothing filter select
    output logic sample_sw_q, // Integrator sampling switch on
    output logic deint_sw_q, // Reference deintegration switch on
    output logic [sdc_pkg::CNT_W-1:0] conv_count_q, // Conversion result count
    output logic conv_done_q, // Conversion finished normally
    output logic busy_q, // Conversion in progress
    output logic fault_too_long_q, // Integrator did not return to zero in time
    output logic fault_too_short_q // Integrator already at zero at deintegration start
);
    import sdc_pkg::*;

    // Divider state
    logic [NCO_W-1:0] acc_q;
    logic [NCO_W-1:0] acc_d;
    logic [NCO_W-1:0] nco_inc;
    logic step_clk_d;
    logic [ADDR_W-1:0] div_sq_d;
    logic [1:0] filter_sel_d;
    logic [ADDR_W-1:0] ref_addr;

    // Converter state
    sdc_conv_state_t state_q;
    sdc_conv_state_t state_d;
    logic [SAMP_W-1:0] samp_cnt_q;
    logic [SAMP_W-1:0] samp_cnt_d;
    logic [TMO_W-1:0] tmo_cnt_q;
    logic [TMO_W-1:0] tmo_cnt_d;
    logic sample_sw_d;
    logic deint_sw_d;
    logic [CNT_W-1:0] conv_count_d;
    logic conv_done_d;
    logic busy_d;
    logic fault_too_long_d;
    logic fault_too_short_d;

    // Accumulator increment for the selected step rate
    always_comb begin
        nco_inc = NCO_INC_100;
        unique case (freq_sel)
            FREQ_100HZ: nco_inc = NCO_INC_100;
            FREQ_120HZ: nco_inc = NCO_INC_120;
            FREQ_1KHZ: nco_inc = NCO_INC_1K;
            FREQ_10KHZ: nco_inc = NCO_INC_10K;
        endcase
    end

    // Phase accumulator divides the clock; each overflow is one step clock edge
    always_comb begin
        logic carry;
        carry = 1'b0;
        {carry, acc_d} = {1'b0, acc_q} + {1'b0, nco_inc};
        step_clk_d = step_clk_q ^ carry;
        div_sq_d = div_sq_q;
        // Halving chain advances on the falling edge of the step clock
        if (carry && step_clk_q) begin
            div_sq_d = div_sq_q + 6'h01;
        end
        filter_sel_d = freq_sel;
    end

    // Divider registers
    always_ff @(posedge clk) begin
        if (srst) begin
            acc_q <= '0;
            step_clk_q <= 1'b0;
            div_sq_q <= ADDR_RST;
            filter_sel_q <= FREQ_100HZ;
        end else begin
            acc_q <= acc_d;
            step_clk_q <= step_clk_d;
            div_sq_q <= div_sq_d;
            filter_sel_q <= filter_sel_d;
        end
    end

    // Reference address: the phase code rotates the quadrant lines (2f and f)
    always_comb begin
        ref_addr = div_sq_q + {phase_sel, 4'h0};
    end

    // Test sine table, addressed straight from the divider
    sdc_sine_rom u_test_rom (
        .clk(clk),
        .srst(srst),
        .addr(div_sq_q),
        .data_q(test_dac_q)
    );

    // Reference sine table, same address at zero phase unless shifted
    sdc_sine_rom u_ref_rom (
        .clk(clk),
        .srst(srst),
        .addr(ref_addr),
        .data_q(ref_dac_q)
    );

    // Converter sequencer: sample, deintegrate, count, check faults
    always_comb begin
        logic samp_end;
        logic start_deint;
        state_d = state_q;
        samp_cnt_d = samp_cnt_q;
        tmo_cnt_d = tmo_cnt_q;
        sample_sw_d = sample_sw_q;
        deint_sw_d = deint_sw_q;
        conv_count_d = conv_count_q;
        conv_done_d = conv_done_q;
        busy_d = busy_q;
        fault_too_long_d = fault_too_long_q;
        fault_too_short_d = fault_too_short_q;
        samp_end = (samp_cnt_q == SAMP_W'(SAMPLE_CYCLES - 1));
        start_deint = 1'b0;
        unique case (state_q)
            SDC_IDLE: begin
                // Only the processor start pulse launches a conversion
                if (conv_start) begin
                    state_d = SDC_SAMPLE;
                    sample_sw_d = 1'b1;
                    deint_sw_d = 1'b0;
                    samp_cnt_d = '0;
                    tmo_cnt_d = '0;
                    conv_count_d = '0;
                    conv_done_d = 1'b0;
                    busy_d = 1'b1;
                    fault_too_long_d = 1'b0;
                    fault_too_short_d = 1'b0;
                end
            end
            SDC_SAMPLE: begin
                samp_cnt_d = samp_cnt_q + 17'h00001;
                // Limit comparator or the end of sampling starts deintegration
                start_deint = !deint_sw_q && (!integrator_limit_n || samp_end);
                if (start_deint && !zero_cross_compare_n) begin
                    // Already at zero or wrong polarity: abort
                    state_d = SDC_IDLE;
                    sample_sw_d = 1'b0;
                    deint_sw_d = 1'b0;
                    busy_d = 1'b0;
                    fault_too_short_d = 1'b1;
                end else begin
                    if (start_deint) begin
                        deint_sw_d = 1'b1;
                    end
                    // Overlapped deintegration is counted as well
                    if (deint_sw_q) begin
                        conv_count_d = conv_count_q + 16'h0001;
                        tmo_cnt_d = tmo_cnt_q + 17'h00001;
                    end
                    if (samp_end) begin
                        sample_sw_d = 1'b0;
                        state_d = SDC_DEINT;
                    end
                end
            end
            SDC_DEINT: begin
                if (!zero_cross_compare_n) begin
                    // Zero reached: stop and hold the count as the result
                    state_d = SDC_IDLE;
                    deint_sw_d = 1'b0;
                    busy_d = 1'b0;
                    conv_done_d = 1'b1;
                end else if (tmo_cnt_q == TMO_W'(TIMEOUT_CYCLES - 1)) begin
                    state_d = SDC_IDLE;
                    deint_sw_d = 1'b0;
                    busy_d = 1'b0;
                    fault_too_long_d = 1'b1;
                end else begin
                    conv_count_d = conv_count_q + 16'h0001;
                    tmo_cnt_d = tmo_cnt_q + 17'h00001;
                end
            end
            default: begin
                state_d = SDC_IDLE;
                sample_sw_d = 1'b0;
                deint_sw_d = 1'b0;
                busy_d = 1'b0;
            end
        endcase
    end

    // Converter registers
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= SDC_IDLE;
            samp_cnt_q <= '0;
            tmo_cnt_q <= '0;
            sample_sw_q <= 1'b0;
            deint_sw_q <= 1'b0;
            conv_count_q <= '0;
            conv_done_q <= 1'b0;
            busy_q <= 1'b0;
            fault_too_long_q <= 1'b0;
            fault_too_short_q <= 1'b0;
        end else begin
            state_q <= state_d;
            samp_cnt_q <= samp_cnt_d;
            tmo_cnt_q <= tmo_cnt_d;
            sample_sw_q <= sample_sw_d;
            deint_sw_q <= deint_sw_d;
            conv_count_q <= conv_count_d;
            conv_done_q <= conv_done_d;
            busy_q <= busy_d;
            fault_too_long_q <= fault_too_long_d;
            fault_too_short_q <= fault_too_short_d;
        end
    end

endmodule
`default_nettype wire

// file: sdc_ctrl_bench.sv
// Self-checking bench for the sine reference and converter control block
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl_bench;
    import sdc_pkg::*;
    logic clk = 1'b0, srst = 1'b1, conv_start = 1'b0, stuck = 1'b0, bz = 1'b0, pv = 1'b0, ov = 1'b0;
    logic [1:0] freq_sel = 2'h0, phase_sel = 2'h0, pp, filter_sel_q;
    logic [7:0] rate = 8'h00, test_dac_q, ref_dac_q;
    logic [5:0] div_sq_q, pa;
    logic [15:0] conv_count_q;
    logic step_clk_q, sample_sw_q, deint_sw_q, conv_done_q, busy_q, fault_too_long_q, fault_too_short_q;
    logic zero_cross_compare_n, integrator_limit_n;
    logic [31:0] lf = 32'h4424;
    logic [3:0] exp_q[$];
    logic [3:0] te[8] = '{4'h4, 4'h4, 4'h4, 4'hc, 4'h1, 4'h2, 4'hc, 4'h4};
    logic [7:0] tr[8] = '{8'h01, 8'h01, 8'h01, 8'h28, 8'h00, 8'h02, 8'h14, 8'h01};
    logic [31:0] inc[4] = '{NCO_INC_100, NCO_INC_120, NCO_INC_1K, NCO_INC_10K};
    int hz[4] = '{F100_HZ, F120_HZ, F1K_HZ, F10K_HZ};
    int nt[4] = '{1, 1, 4, 128};
    int n_errors = 0, samples_checked = 0, dcyc = 0;

    sdc_ctrl #(.SAMPLE_CYCLES(16), .TIMEOUT_CYCLES(1024)) DUT (
        .clk(clk), .srst(srst), .freq_sel(freq_sel), .phase_sel(phase_sel), .conv_start(conv_start),
        .zero_cross_compare_n(zero_cross_compare_n), .integrator_limit_n(integrator_limit_n),
        .step_clk_q(step_clk_q), .div_sq_q(div_sq_q), .test_dac_q(test_dac_q), .ref_dac_q(ref_dac_q),
        .filter_sel_q(filter_sel_q), .sample_sw_q(sample_sw_q), .deint_sw_q(deint_sw_q),
        .conv_count_q(conv_count_q), .conv_done_q(conv_done_q), .busy_q(busy_q),
        .fault_too_long_q(fault_too_long_q), .fault_too_short_q(fault_too_short_q));
    sdc_integ_model u_integ (
        .clk(clk), .srst(srst), .sample_sw(sample_sw_q), .deint_sw(deint_sw_q), .rate(rate), .stuck(stuck),
        .zero_cross_compare_n(zero_cross_compare_n), .integrator_limit_n(integrator_limit_n));

    // Free-running 200 MHz clock
    initial forever #2.5 clk = ~clk;

    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Ideal 64-step offset-binary sine word
    function automatic logic [7:0] sine(input int k);
        return 8'($rtoi(128.0 + 127.0 * $sin(6.283185307179586 * (k % 64) / 64.0) + 0.5));
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task results;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One conversion from the table; entry 1 holds start while busy
    task automatic conv(input int i);
        int c;
        @(posedge clk);
        rate <= (i < 3) ? 8'(1 + lf[1:0] % 3) : tr[i];
        stuck <= (i == 5);
        conv_start <= 1'b1;
        exp_q.push_back(te[i]);
        lf = nxt(lf);
        repeat ((i == 1) ? 3 : 1) @(posedge clk);
        conv_start <= 1'b0;
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (busy_q !== 1'b0 && c < 3000);
    endtask

    // Count clocks over a number of step clock half periods
    task automatic per(input int f);
        int c, e;
        logic s;
        @(posedge clk);
        freq_sel <= 2'(f);
        phase_sel <= lf[1:0];
        lf = nxt(lf);
        c = 0;
        @(negedge clk);
        s = step_clk_q;
        while (step_clk_q === s && c < 40000) begin
            @(negedge clk);
            c++;
        end
        c = 0;
        repeat (nt[f]) begin
            s = step_clk_q;
            do begin
                @(negedge clk);
                c++;
            end while (step_clk_q === s && c < 40000);
        end
        e = $rtoi(nt[f] * 4294967296.0 / inc[f] + 0.5);
        check(32'(c >= e - 1 && c <= e + 1), 32'h1);
        check(32'(e * 128.0 * hz[f] > nt[f] * 0.99 * CLK_HZ && e * 128.0 * hz[f] < nt[f] * 1.01 * CLK_HZ), 32'h1);
    endtask

    // Conversion outcome against the oldest note
    always @(negedge clk) begin
        if (busy_q === 1'b1 && !bz) begin
            dcyc = 0;
            ov = 1'b0;
        end
        if (deint_sw_q === 1'b1) dcyc++;
        if (sample_sw_q === 1'b1 && deint_sw_q === 1'b1) ov = 1'b1;
        if (bz && busy_q === 1'b0 && exp_q.size() > 0) begin
            check({ov, conv_done_q, fault_too_long_q, fault_too_short_q}, exp_q[0]);
            if (exp_q[0][2]) check(conv_count_q, 32'(dcyc - 1));
            if (exp_q[0][1]) check(conv_count_q, 32'd1023);
            void'(exp_q.pop_front());
        end
        bz = (busy_q === 1'b1);
    end

    // Sine words one clock behind the step counter
    always @(negedge clk) begin
        if (srst === 1'b0 && pv) begin
            check(test_dac_q, sine(pa));
            check(ref_dac_q, sine(pa + 16 * pp));
        end
        pv = (srst === 1'b0);
        pa = div_sq_q;
        pp = phase_sel;
    end

    // Main sequence: one slow-rate measurement of eight readings, then every frequency
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++) conv(i);
        for (int f = 3; f >= 0; f--) per(f);
        results();
    end

    // Watchdog: conversions take about 2.3k clocks and the four period scans about 86k
    initial begin
        repeat (98000) @(posedge clk);
        n_errors++;
        results();
    end
endmodule
`default_nettype wire

// file: sdc_ctrl_dummy_never.sv
// Empty source unit that holds no design code
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: sdc_ctrl_props.sv
// Concurrent checks on the converter sequencer and divider ports
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl_props #(
    parameter int SAMPLE_CYCLES = 16, // Sampling interval in clocks
    parameter int TIMEOUT_CYCLES = 64 // Deintegration timeout in clocks
) (
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic [1:0] freq_sel, // Frequency code
    input wire logic conv_start, // Start request
    input wire logic zero_cross_compare_n, // Zero comparator
    input wire logic integrator_limit_n, // Limit comparator
    input wire logic step_clk_q, // Step clock
    input wire logic [sdc_pkg::ADDR_W-1:0] div_sq_q, // Step counter
    input wire logic [1:0] filter_sel_q, // Filter select
    input wire logic sample_sw_q, // Sampling switch
    input wire logic deint_sw_q, // Deintegration switch
    input wire logic [sdc_pkg::CNT_W-1:0] conv_count_q, // Result count
    input wire logic conv_done_q, // Done flag
    input wire logic busy_q, // Busy flag
    input wire logic fault_too_long_q, // Timeout fault
    input wire logic fault_too_short_q // Already-zero fault
);
    import sdc_pkg::*;
    logic [15:0] samp_len_q;
    logic [15:0] samp_len_d;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Length of the current sampling run
    always_comb samp_len_d = sample_sw_q ? samp_len_q + 16'h0001 : 16'h0000;
    always_ff @(posedge clk) samp_len_q <= srst ? 16'h0000 : samp_len_d;

    a_filter_follows: assert property (!$past(srst) |-> filter_sel_q == $past(freq_sel))
        else $error("filter select does not follow frequency");
    a_div_step: assert property (!$past(srst) && $changed(div_sq_q) |-> $fell(step_clk_q) && div_sq_q == $past(div_sq_q) + 6'h01)
        else $error("step counter moved without a step clock fall");
    a_start_accept: assert property (!busy_q && conv_start |=> busy_q && sample_sw_q && !conv_done_q && !fault_too_long_q && !fault_too_short_q && conv_count_q == 16'h0000)
        else $error("start not accepted cleanly");
    a_sample_len: assert property (!$past(srst) && $fell(sample_sw_q) && !fault_too_short_q |-> samp_len_q == SAMPLE_CYCLES && deint_sw_q)
        else $error("sampling interval length wrong");
    a_limit_overlap: assert property (sample_sw_q && !integrator_limit_n && zero_cross_compare_n && samp_len_q < SAMPLE_CYCLES - 1 |=> deint_sw_q && sample_sw_q)
        else $error("limit did not start early deintegration");
    a_short_fault: assert property (sample_sw_q && !deint_sw_q && !zero_cross_compare_n && (samp_len_q == SAMPLE_CYCLES - 1 || !integrator_limit_n) |=> fault_too_short_q && !busy_q && !sample_sw_q)
        else $error("already-zero start not flagged");
    a_done_zero: assert property (deint_sw_q && !sample_sw_q && !zero_cross_compare_n |=> conv_done_q && !busy_q && !deint_sw_q && conv_count_q == $past(conv_count_q))
        else $error("zero crossing did not end conversion");
    a_count_gate: assert property (!deint_sw_q && !(conv_start && !busy_q) |=> $stable(conv_count_q))
        else $error("count moved outside deintegration");
    a_timeout_bound: assert property (deint_sw_q |-> conv_count_q < TIMEOUT_CYCLES)
        else $error("deintegration ran past timeout");
    a_fault_abort: assert property ($rose(fault_too_long_q) || $rose(fault_too_short_q) |-> !busy_q && !sample_sw_q && !deint_sw_q)
        else $error("fault did not abort conversion");
    c_overlap: cover property (deint_sw_q && sample_sw_q);
    c_done: cover property ($rose(conv_done_q));
    c_long: cover property ($rose(fault_too_long_q));
    c_short: cover property ($rose(fault_too_short_q));
endmodule
bind sdc_ctrl sdc_ctrl_props #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (
    .clk(clk), .srst(srst), .freq_sel(freq_sel), .conv_start(conv_start),
    .zero_cross_compare_n(zero_cross_compare_n), .integrator_limit_n(integrator_limit_n),
    .step_clk_q(step_clk_q), .div_sq_q(div_sq_q), .filter_sel_q(filter_sel_q), .sample_sw_q(sample_sw_q),
    .deint_sw_q(deint_sw_q), .conv_count_q(conv_count_q), .conv_done_q(conv_done_q), .busy_q(busy_q),
    .fault_too_long_q(fault_too_long_q), .fault_too_short_q(fault_too_short_q));
`default_nettype wire

// file: sdc_integ_model.sv
// Behavioural integrator with zero and limit comparators
`timescale 1ns/1ps
`default_nettype none
module sdc_integ_model #(
    parameter int LIMIT = 200 // Level that trips the limit comparator
) (
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic sample_sw, // Sampling switch
    input wire logic deint_sw, // Deintegration switch
    input wire logic [7:0] rate, // Charge per sampling clock
    input wire logic stuck, // Discharge makes no progress
    output logic zero_cross_compare_n, // Low at or below zero
    output logic integrator_limit_n // Low at or above limit
);
    int level_q = 0;
    // Charge while sampling, lose one step per clock while deintegrating unless stuck
    always @(posedge clk) begin
        if (srst || (!sample_sw && !deint_sw)) begin
            level_q <= 0;
        end else begin
            level_q <= level_q + (sample_sw ? int'(rate) : 0) - ((deint_sw && !stuck) ? 1 : 0);
        end
    end
    // Comparators follow the held charge
    assign zero_cross_compare_n = (level_q > 0);
    assign integrator_limit_n = (level_q < LIMIT);
endmodule
`default_nettype wire

// file: sdc_pkg.sv
// Shared constants and types for the sine reference and dual-slope converter control block
package sdc_pkg;

    // System clock
    localparam int CLK_HZ = 200_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;

    // Numerically controlled divider: phase accumulator width
    localparam int NCO_W = 32;

    // Half-steps per test period: 64 steps, two edges of the step clock each
    localparam int HALF_STEPS = 128;

    // Selectable test frequencies in Hz
    localparam int F100_HZ = 100;
    localparam int F120_HZ = 120;
    localparam int F1K_HZ = 1000;
    localparam int F10K_HZ = 10000;

    // Accumulator increments that give the step clock (64 f) for each frequency
    localparam logic [NCO_W-1:0] NCO_INC_100 = NCO_W'((64'(HALF_STEPS * F100_HZ) << NCO_W) / 64'(CLK_HZ));
    localparam logic [NCO_W-1:0] NCO_INC_120 = NCO_W'((64'(HALF_STEPS * F120_HZ) << NCO_W) / 64'(CLK_HZ));
    localparam logic [NCO_W-1:0] NCO_INC_1K = NCO_W'((64'(HALF_STEPS * F1K_HZ) << NCO_W) / 64'(CLK_HZ));
    localparam logic [NCO_W-1:0] NCO_INC_10K = NCO_W'((64'(HALF_STEPS * F10K_HZ) << NCO_W) / 64'(CLK_HZ));

    // Frequency select codes
    localparam logic [1:0] FREQ_100HZ = 2'h0;
    localparam logic [1:0] FREQ_120HZ = 2'h1;
    localparam logic [1:0] FREQ_1KHZ = 2'h2;
    localparam logic [1:0] FREQ_10KHZ = 2'h3;

    // Reference phase select codes (quarter cycles of advance)
    localparam logic [1:0] PH_0 = 2'h0;
    localparam logic [1:0] PH_90 = 2'h1;
    localparam logic [1:0] PH_180 = 2'h2;
    localparam logic [1:0] PH_270 = 2'h3;

    // Sine table geometry
    localparam int ADDR_W = 6;
    localparam int DAC_W = 8;
    localparam int QTR_LSB = 4;
    localparam logic [DAC_W-1:0] DAC_MID = 8'h80;
    localparam logic [ADDR_W-1:0] ADDR_RST = 6'h00;
    localparam logic [4:0] QTR_FULL = 5'h10;

    // Sampling interval and deintegration timeout
    localparam int SAMPLE_TIME_NS = 100_000;
    localparam int SAMPLE_CYC = (SAMPLE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int DEINT_TIMEOUT_NS = 325_000;
    localparam int TIMEOUT_CYC = (DEINT_TIMEOUT_NS * CLK_MHZ) / 1000;

    // Counter widths and the largest conversion count still valid
    localparam int SAMP_W = 17;
    localparam int CNT_W = 16;
    localparam int TMO_W = 17;
    localparam logic [CNT_W-1:0] MAX_VALID_COUNT = 16'hea60;

    // Converter sequencer states
    typedef enum logic [1:0] {
        SDC_IDLE,
        SDC_SAMPLE,
        SDC_DEINT
    } sdc_conv_state_t;

endpackage

// file: sdc_sine_rom.sv
// Registered 64-step sine lookup table, offset-binary output
`timescale 1ns/1ps
`default_nettype none
module sdc_sine_rom (
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic [sdc_pkg::ADDR_W-1:0] addr, // Step index within one cycle
    output logic [sdc_pkg::DAC_W-1:0] data_q // Sample word to the converter
);
    import sdc_pkg::*;

    logic [DAC_W-1:0] data_d;

    // Quarter-wave magnitudes, 127 * sin(m * 90 / 16 degrees)
    function automatic logic [DAC_W-1:0] qtr_mag(input logic [4:0] m);
        logic [DAC_W-1:0] v;
        v = 8'h00;
        unique case (m)
            5'h00: v = 8'h00;
            5'h01: v = 8'h0c;
            5'h02: v = 8'h19;
            5'h03: v = 8'h25;
            5'h04: v = 8'h31;
            5'h05: v = 8'h3c;
            5'h06: v = 8'h47;
            5'h07: v = 8'h51;
            5'h08: v = 8'h5a;
            5'h09: v = 8'h62;
            5'h0a: v = 8'h6a;
            5'h0b: v = 8'h70;
            5'h0c: v = 8'h75;
            5'h0d: v = 8'h7a;
            5'h0e: v = 8'h7d;
            5'h0f: v = 8'h7e;
            5'h10: v = 8'h7f;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // Fold the full cycle onto the quarter table by quadrant symmetry
    always_comb begin
        logic [4:0] m;
        logic [DAC_W-1:0] mag;
        m = {1'b0, addr[QTR_LSB-1:0]};
        if (addr[QTR_LSB]) begin
            m = QTR_FULL - m;
        end
        mag = qtr_mag(m);
        if (addr[ADDR_W-1]) begin
            data_d = DAC_MID - mag;
        end else begin
            data_d = DAC_MID + mag;
        end
    end

    // Output register
    always_ff @(posedge clk) begin
        if (srst) begin
            data_q <= DAC_MID;
        end else begin
            data_q <= data_d;
        end
    end

endmodule
`default_nettype wire
